/* ddac_pkg.sv */
// package for the dual converter control block: register offsets, reset values, bit positions
// assumes an 8-bit special-function register bus with byte addresses
package ddac_pkg;
   localparam logic [7:0] CONV0_DATA_LOW_ADDR = 8'hF9;
   localparam logic [7:0] CONV0_DATA_HIGH_ADDR = 8'hFA;
   localparam logic [7:0] CONV1_DATA_LOW_ADDR = 8'hFB;
   localparam logic [7:0] CONV1_DATA_HIGH_ADDR = 8'hFC;
   localparam logic [7:0] CONV_CONTROL_ADDR = 8'hFD;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [7:0] CONTROL_RESET = 8'h04;
   localparam int BIT_MODE = 7;
   localparam int BIT_RANGE_SEL_1 = 6;
   localparam int BIT_RANGE_SEL_0 = 5;
   localparam int BIT_OUT_CLEAR_1 = 4;
   localparam int BIT_OUT_CLEAR_0 = 3;
   localparam int BIT_SYNC = 2;
   localparam int BIT_POWER_EN_1 = 1;
   localparam int BIT_POWER_EN_0 = 0;

   // register bus request from the core
   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } ddac_bus_t;

   // per-converter outputs toward the analog part
   typedef struct packed {
      logic [11:0] code;
      logic rangeSupply;
      logic clearOut;
      logic powerEn;
   } ddac_chan_t;
endpackage : ddac_pkg

/* ddac_control.sv */
// dual 12-bit converter control: five byte registers on the core register bus, update logic
// assumes the core bus is on clk_sys and presents one-cycle read and write strobes
`timescale 1ns/1ps
module ddac_control
   import ddac_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input ddac_pkg::ddac_bus_t busReq,
   output logic [7:0] rdData,
   output logic rdHit,
   output ddac_pkg::ddac_chan_t chan0,
   output ddac_pkg::ddac_chan_t chan1
);
   import ddac_pkg::*;

   // ************************************************************
   // register file
   // ************************************************************
   // byte registers, output codes and the registered read answer
   logic [7:0] low0_q, low0_d, high0_q, high0_d;
   logic [7:0] low1_q, low1_d, high1_q, high1_d;
   logic [7:0] ctrl_q, ctrl_d;
   logic [11:0] code0_q, code0_d, code1_q, code1_d;
   logic [7:0] rdData_q, rdData_d;
   logic rdHit_q, rdHit_d;
   logic [4:0] wrSel, rdSel;
   logic wrLow0, wrLow1, syncRise;

   // code formed from one converter's byte pair under the current mode
   function automatic logic [11:0] formCode(input logic [7:0] lo, input logic [7:0] hi,
                                            input logic eightBit);
      if (eightBit) begin
         formCode = {4'h0, lo};
      end else begin
         formCode = {hi[3:0], lo};
      end
   endfunction : formCode

   // one-hot select: bit 0 low0, 1 high0, 2 low1, 3 high1, 4 control
   function automatic logic [4:0] decodeAddr(input logic [7:0] addr);
      case (addr)
         CONV0_DATA_LOW_ADDR: decodeAddr = 5'h01;
         CONV0_DATA_HIGH_ADDR: decodeAddr = 5'h02;
         CONV1_DATA_LOW_ADDR: decodeAddr = 5'h04;
         CONV1_DATA_HIGH_ADDR: decodeAddr = 5'h08;
         CONV_CONTROL_ADDR: decodeAddr = 5'h10;
         default: decodeAddr = 5'h00;
      endcase
   endfunction : decodeAddr

   // ************************************************************
   // address decode
   // ************************************************************
   // unmapped addresses select nothing: writes drop, reads miss
   always_comb begin
      wrSel = 5'h00;
      rdSel = 5'h00;
      if (busReq.wrEn) begin
         wrSel = decodeAddr(busReq.addr);
      end
      if (busReq.rdEn) begin
         rdSel = decodeAddr(busReq.addr);
      end
   end

   // ************************************************************
   // control register
   // ************************************************************
   always_comb begin
      ctrl_d = ctrl_q;
      if (wrSel[4]) begin
         ctrl_d = busReq.wrData;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         ctrl_q <= CONTROL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // ************************************************************
   // converter 0 data bytes
   // ************************************************************
   always_comb begin
      low0_d = low0_q;
      high0_d = high0_q;
      if (wrSel[0]) begin
         low0_d = busReq.wrData;
      end
      if (wrSel[1]) begin
         high0_d = busReq.wrData;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         low0_q <= DATA_RESET;
         high0_q <= DATA_RESET;
      end else begin
         low0_q <= low0_d;
         high0_q <= high0_d;
      end
   end

   // ************************************************************
   // converter 1 data bytes
   // ************************************************************
   always_comb begin
      low1_d = low1_q;
      high1_d = high1_q;
      if (wrSel[2]) begin
         low1_d = busReq.wrData;
      end
      if (wrSel[3]) begin
         high1_d = busReq.wrData;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         low1_q <= DATA_RESET;
         high1_q <= DATA_RESET;
      end else begin
         low1_q <= low1_d;
         high1_q <= high1_d;
      end
   end

   // ************************************************************
   // output update
   // ************************************************************
   always_comb begin
      wrLow0 = wrSel[0];
      wrLow1 = wrSel[2];
      syncRise = ctrl_d[BIT_SYNC] && !ctrl_q[BIT_SYNC];
      code0_d = code0_q;
      code1_d = code1_q;
      if (syncRise) begin
         // held data goes out on both converters together
         code0_d = formCode(low0_d, high0_d, ctrl_d[BIT_MODE]);
         code1_d = formCode(low1_d, high1_d, ctrl_d[BIT_MODE]);
      end else if (ctrl_q[BIT_SYNC]) begin
         // low byte write completes the code
         if (wrLow0) begin
            code0_d = formCode(low0_d, high0_d, ctrl_q[BIT_MODE]);
         end
         if (wrLow1) begin
            code1_d = formCode(low1_d, high1_d, ctrl_q[BIT_MODE]);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         code0_q <= 12'h000;
         code1_q <= 12'h000;
      end else begin
         code0_q <= code0_d;
         code1_q <= code1_d;
      end
   end

   // ************************************************************
   // read path
   // ************************************************************
   always_comb begin
      rdData_d = 8'h00;
      rdHit_d = |rdSel;
      case (rdSel)
         5'h01: rdData_d = low0_q;
         5'h02: rdData_d = high0_q;
         5'h04: rdData_d = low1_q;
         5'h08: rdData_d = high1_q;
         5'h10: rdData_d = ctrl_q;
         default: rdData_d = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rdData_q <= 8'h00;
         rdHit_q <= 1'b0;
      end else begin
         rdData_q <= rdData_d;
         rdHit_q <= rdHit_d;
      end
   end

   // ************************************************************
   // read answer outputs and analog-side controls
   // ************************************************************
   always_comb begin
      rdData = rdData_q;
      rdHit = rdHit_q;
      chan0.code = code0_q;
      chan1.code = code1_q;
      chan1.rangeSupply = ctrl_q[BIT_RANGE_SEL_1];
      chan0.rangeSupply = ctrl_q[BIT_RANGE_SEL_0];
      chan1.clearOut = !ctrl_q[BIT_OUT_CLEAR_1];
      chan0.clearOut = !ctrl_q[BIT_OUT_CLEAR_0];
      chan1.powerEn = ctrl_q[BIT_POWER_EN_1];
      chan0.powerEn = ctrl_q[BIT_POWER_EN_0];
   end
endmodule : ddac_control

/* ddac_control_props.sv */
// checker for the dual converter control block
// assumes binding to ddac_control, single clock domain
`timescale 1ns/1ps
module ddac_control_props
   import ddac_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input ddac_pkg::ddac_bus_t busReq,
   input wire logic [7:0] rdData,
   input wire logic rdHit,
   input ddac_pkg::ddac_chan_t chan0,
   input ddac_pkg::ddac_chan_t chan1
);
   // ****************
   // shadow state
   // ****************
   logic [7:0] ctlQ;
   logic [7:0] hiQ;
   logic wLo;
   logic wHi;
   logic wCtl;
   assign wLo = busReq.wrEn && busReq.addr == CONV0_DATA_LOW_ADDR;
   assign wHi = busReq.wrEn && busReq.addr == CONV0_DATA_HIGH_ADDR;
   assign wCtl = busReq.wrEn && busReq.addr == CONV_CONTROL_ADDR;
   always_ff @(posedge clk_sys) begin
      ctlQ <= !rst_b ? CONTROL_RESET : wCtl ? busReq.wrData : ctlQ;
      hiQ <= !rst_b ? DATA_RESET : wHi ? busReq.wrData : hiQ;
   end
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   chk_low_update: assert property (wLo && ctlQ[BIT_SYNC] |=> chan0.code ==
      (ctlQ[BIT_MODE] ? {4'h0, $past(busReq.wrData)} : {hiQ[3:0], $past(busReq.wrData)}))
      else $error("chan0 code not loaded from low byte");
   chk_low_held: assert property (wLo && !ctlQ[BIT_SYNC] |=> $stable(chan0.code))
      else $error("chan0 code moved while held");
   chk_high_quiet: assert property (wHi |=> $stable(chan0.code))
      else $error("high byte write moved chan0 code");
   chk_power_map: assert property (wCtl |=> chan0.powerEn == $past(busReq.wrData[0])
      && chan1.powerEn == $past(busReq.wrData[1])) else $error("power enable mismatch");
   chk_range_map: assert property (wCtl |=> chan0.rangeSupply == $past(busReq.wrData[5])
      && chan1.rangeSupply == $past(busReq.wrData[6])) else $error("range select mismatch");
   chk_clear_map: assert property (wCtl |=> chan0.clearOut != $past(busReq.wrData[3])
      && chan1.clearOut != $past(busReq.wrData[4])) else $error("clear control mismatch");
   chk_reset_off: assert property ($rose(rst_b) |-> !chan0.powerEn && !chan1.powerEn)
      else $error("converter powered after reset");
   chk_read_hit: assert property (busReq.rdEn |=> rdHit ==
      ($past(busReq.addr) inside {[CONV0_DATA_LOW_ADDR:CONV_CONTROL_ADDR]}))
      else $error("read acknowledge mismatch");
   chk_ctl_read: assert property (busReq.rdEn && !busReq.wrEn && busReq.addr ==
      CONV_CONTROL_ADDR |=> rdData == ctlQ) else $error("control readback mismatch");
   cover property (wLo && ctlQ[BIT_SYNC]);
   cover property (wCtl && !ctlQ[BIT_SYNC] && busReq.wrData[BIT_SYNC]);
   cover property (busReq.rdEn ##1 !rdHit);
endmodule : ddac_control_props

/* tb_ddac_control.sv */
// self-checking bench for the dual converter control block
// assumes ddac_control_props compiled before this file
`timescale 1ns/1ps
module tb_ddac_control;
   import ddac_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   ddac_bus_t busReq = '0;
   logic [7:0] rdData;
   logic rdHit;
   ddac_chan_t chan0;
   ddac_chan_t chan1;
   int n_fail = 0;
   int compares = 0;
   int cycles = 0;
   ddac_control u_ddac_control(.clk_sys(clk_sys), .rst_b(rst_b), .busReq(busReq),
      .rdData(rdData), .rdHit(rdHit), .chan0(chan0), .chan1(chan1));
   initial forever #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 500) begin
         n_fail++;
         stop_test();
      end
   end
   // ****************
   // tasks
   // ****************
   task automatic stop_test();
      if (n_fail == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test
   task automatic cmp(input string what, input logic [14:0] exp, input logic [14:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s exp %h got %h", what, exp, got);
      end
   endtask : cmp
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys) busReq = '{1'b1, 1'b0, a, d};
      @(negedge clk_sys) busReq = '0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_sys) busReq = '{1'b0, 1'b1, a, 8'h00};
      @(negedge clk_sys) busReq = '0;
      cmp("rdData", {7'h00, exp}, {7'h00, rdData});
      cmp("rdHit", {14'h0000, a inside {[8'hF9:8'hFD]}}, {14'h0000, rdHit});
   endtask : rd
   task automatic t_reset();
      wr(8'hF8, 8'hFF);
      wr(8'hFE, 8'hFF);
      for (int i = 0; i < 5; i++) rd(8'(8'hF9 + i), (i == 4) ? 8'h04 : 8'h00);
      rd(8'hF8, 8'h00);
      cmp("chan0", {12'h000, 3'b010}, chan0);
      cmp("chan1", {12'h000, 3'b010}, chan1);
   endtask : t_reset
   task automatic t_imm();
      wr(8'hFD, 8'h7F);
      wr(8'hFA, 8'hA5);
      cmp("chan0", {12'h000, 3'b101}, chan0);
      wr(8'hF9, 8'h3C);
      cmp("chan0", {12'h53C, 3'b101}, chan0);
      wr(8'hFC, 8'hF2);
      wr(8'hFB, 8'h77);
      cmp("chan1", {12'h277, 3'b101}, chan1);
      rd(8'hFC, 8'hF2);
      wr(8'hFD, 8'hFF);
      wr(8'hF9, 8'h81);
      cmp("chan0", {12'h081, 3'b101}, chan0);
   endtask : t_imm
   task automatic t_sync();
      wr(8'hFD, 8'h52);
      wr(8'hFA, 8'h0A);
      wr(8'hF9, 8'hBC);
      wr(8'hFC, 8'h01);
      wr(8'hFB, 8'h23);
      cmp("chan0", {12'h081, 3'b010}, chan0);
      cmp("chan1", {12'h277, 3'b101}, chan1);
      wr(8'hFD, 8'h56);
      cmp("chan0", {12'hABC, 3'b010}, chan0);
      cmp("chan1", {12'h123, 3'b101}, chan1);
   endtask : t_sync
   initial begin
      repeat (6) @(negedge clk_sys);
      rst_b = 1'b1;
      t_reset();
      t_imm();
      t_sync();
      stop_test();
   end
endmodule : tb_ddac_control
bind ddac_control ddac_control_props u_ddac_control_props(.clk_sys(clk_sys), .rst_b(rst_b),
   .busReq(busReq), .rdData(rdData), .rdHit(rdHit), .chan0(chan0), .chan1(chan1));
